//--- dv/async_rx_buffer_and_modem_ctl_test.sv
// self-checking bench for the receive control block
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_defines.vh"
module async_rx_buffer_and_modem_ctl_test;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, init_i = 1'b0, psel = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, reverse_channel_rx_i = 1'b0, pend;
  logic ce_i = 1'b1, err;
  logic [11:0] paddr = 12'h000, f;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0] cfg, d;
  logic [15:0] ex;
  wire [31:0] prdata;
  wire pready, pslverr, rxd_i, reverse_channel_tx_o, request_to_send_o;
  wire force_busy_o, data_terminal_ready_o, reader_advance_o, receiver_done_o;
  wire [4:0] pins = {reverse_channel_tx_o, force_busy_o, request_to_send_o,
    data_terminal_ready_o, reader_advance_o};
  integer n_errors = 0, checks_done = 0, seed = 3, i, k, j;
  logic [9:0] tbl [0:5] = '{10'h02d, 10'h12f, 10'h229, 10'h12c, 10'h024,
    10'h30d};
  always #50 ref_clk_i = ~ref_clk_i;
  rx_line_model line_u (.ref_clk_i(ref_clk_i), .rxd_o(rxd_i));
  rx_ctl dut_u (.*, .pstrb(4'hf));
  task ck(input string nm, input logic [31:0] seen, input logic [31:0] x);
    checks_done++;
    if (seen !== x) n_errors++;
    if (seen !== x) $display("mismatch %s expected %h seen %h", nm, x, seen);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    repeat (20) if (pready !== 1'b1) @(posedge ref_clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) n_errors++;
    if (pready !== 1'b1) wrap_up;
  endtask
  // model: frame from config, expected buffer word from flags
  task snd(input logic [1:0] b);
    k = $random(seed);
    d = k[7:0] & (8'hff >> (3 - cfg[3:2]));
    f = {4'h0, d} << 1;
    j = 6 + cfg[3:2];
    f[j] = ^d ^ cfg[1] ^ b[0];
    j = j + cfg[0];
    f[j] = !b[1];
    f[j + 1] = 1'b1;
    line_u.send(f, j + 2);
    ex = {1'b0, {pend, b[1], cfg[0] & b[0]} & {3{cfg[5]}}, 4'h0, d};
    ex[15] = |ex[14:12];
    pend = 1'b1;
  endtask
  initial begin
    pend = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    k = $random(seed);
    reverse_channel_rx_i <= k[0];
    apb(1'b1, `OFS_RX_CONFIG, 32'h2d);
    apb(1'b1, `OFS_RX_CTL_STATUS, 32'he);
    apb(1'b0, `OFS_RX_CTL_STATUS, 32'h0);
    ck("ctl pins", pins, 5'h16);
    ck("ctl read", rd, {k[0], 10'h00e});
    init_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    init_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    ck("init pins", pins, 5'h02);
    apb(1'b1, `OFS_RX_CTL_STATUS, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    ck("advance pins", {pins, receiver_done_o}, 6'h02);
    apb(1'b1, `OFS_RX_CONFIG, 32'h3d);
    apb(1'b1, `OFS_RX_CTL_STATUS, 32'h4);
    repeat (2) @(posedge ref_clk_i);
    ck("busy pins", pins, 5'h09);
    ce_i <= 1'b0;
    init_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    init_i <= 1'b0;
    ce_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    ck("frozen pins", pins, 5'h09);
    apb(1'b1, `OFS_RX_CTL_STATUS, 32'h0);
    $display("control tests end");
    for (i = 0; i < 6; i++) begin
      cfg = tbl[i][7:0];
      apb(1'b1, `OFS_RX_CONFIG, {24'h0, cfg});
      if (i == 4) snd(2'h0);
      snd(tbl[i][9:8]);
      ck("done", {receiver_done_o, reader_advance_o}, 2'h2);
      for (k = 0; k < 2; k++) begin
        apb(1'b0, `OFS_RX_DATA_BUF, 32'h0);
        ck("buffer", rd, ex);
      end
      pend = 1'b0;
      ck("done cleared", receiver_done_o, 1'b0);
      $display("char case %0d end", i);
    end
    apb(1'b0, 12'h00c, 32'h0);
    ck("unmapped", err, 1'b1);
    wrap_up;
  end
endmodule // async_rx_buffer_and_modem_ctl_test
`default_nettype wire

//--- dv/rx_ctl_sva.sv
// assertions on the receive control block ports
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_defines.vh"
module rx_ctl_sva (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire init_i,
  input wire psel,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire reverse_channel_rx_i,
  input wire reverse_channel_tx_o,
  input wire request_to_send_o,
  input wire force_busy_o,
  input wire data_terminal_ready_o,
  input wire reader_advance_o,
  input wire receiver_done_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_buf; pready && !pwrite && paddr == `OFS_RX_DATA_BUF; endsequence
  sequence s_ctl; pready && !pwrite && paddr == `OFS_RX_CTL_STATUS; endsequence
  property p_sum; s_buf |-> prdata[15] == |prdata[14:12]; endproperty
  property p_pad; s_buf |-> prdata[11:8] == 4'h0; endproperty
  property p_adv0; s_ctl |-> !prdata[0]; endproperty
  property p_rev; s_ctl |-> prdata[10] == $past(reverse_channel_rx_i, 2);
  endproperty
  property p_done; s_buf |-> ##1 !receiver_done_o; endproperty
  property p_init; init_i && ce_i |-> ##2 !(reverse_channel_tx_o
    || reader_advance_o
    || request_to_send_o || force_busy_o); endproperty
  property p_dtr; init_i && !psel && !$past(psel)
    |=> $stable(data_terminal_ready_o); endproperty
  property p_rts; !(request_to_send_o && force_busy_o); endproperty
  a_sum: assert property (p_sum) else $error("summary flag");
  a_pad: assert property (p_pad) else $error("unused bits set");
  a_adv0: assert property (p_adv0) else $error("advance bit read");
  a_rev: assert property (p_rev) else $error("reverse rx bit");
  a_done: assert property (p_done) else $error("done kept");
  a_init: assert property (p_init) else $error("init kept");
  a_dtr: assert property (p_dtr) else $error("dtr moved");
  a_rts: assert property (p_rts) else $error("rts on both");
endmodule // rx_ctl_sva
bind rx_ctl rx_ctl_sva sva_u (.*);
`default_nettype wire

//--- dv/rx_line_model.sv
// serial terminal model driving the receive data line
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_defines.vh"
module rx_line_model (
  input wire logic ref_clk_i,
  output logic rxd_o = 1'b1
);
  // frame goes out lsb first, one bit time per bit
  task send(input logic [11:0] f, input integer n);
    integer j;
    for (j = 0; j < n; j++) begin
      rxd_o <= f[j];
      repeat (`BIT_CYCLES) @(posedge ref_clk_i);
    end
  endtask
endmodule // rx_line_model
`default_nettype wire

//--- hw/rx_ctl.v
// receive status/control and data buffer registers behind an apb slave
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_defines.vh"
// Functional notes
// (R1) reverse-channel transmit bit 3 is read/write, set drives space; init clears
// (R2) request-to-send bit 2 read/write, init clears; config bit 4 picks rts or busy
// (R3) data-terminal-ready bit 1 read/write; set connects, clear disconnects
// (R4) init leaves dtr alone; power-up value undefined, software clears it
// (R5) writing one to reader advance bit 0 advances reader, clears done
// (R6) reader advance self-clears at start bit middle; init clears it
// (R7) summary flag bit 15 is or of overrun, framing, parity flags
// (R8) summary flag feeds no interrupt, status only
// (R9) error flags read-only, clear when cause gone
// (R10) flags hold until next character re-evaluates them; init keeps them
// (R11) overrun set when character completes while done still set
// (R12) framing flag set when stop bit invalid
// (R13) parity flag set when parity mismatches configured sense
// (R14) parity flag reads zero when parity not configured
// (R15) buffer low byte holds latest received character
// (R16) short characters right-justified, unused high data bits read zero
// (R17) done set on complete character; cleared by buffer access and init
// (R18) reverse-channel receive bit 10 follows input, space reads one
// (R19) buffer bits 11..8 and reader advance bit read zero
// (R20) without error detection, flag and summary positions read zero
module rx_ctl (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire init_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd_i,
  input wire reverse_channel_rx_i,
  output reg reverse_channel_tx_o,
  output reg request_to_send_o,
  output reg force_busy_o,
  output reg data_terminal_ready_o,
  output reg reader_advance_o,
  output reg receiver_done_o
);
  reg rev_tx;
  reg rts;
  reg dtr;
  reg reader_adv;
  reg rx_int_enb;
  reg rx_done;
  reg rev_rx;
  reg [7:0] rx_char;
  reg ovr_flag;
  reg frm_flag;
  reg par_flag;
  reg [31:0] cfg;
  wire start_mid;
  wire active;
  wire char_done;
  wire [7:0] sh_data;
  wire sh_frm;
  wire sh_par;

  rx_shift u_shift (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .rxd_i(rxd_i),
    .len_sel_i(cfg[`CFG_LEN_LSB+1:`CFG_LEN_LSB]),
    .par_en_i(cfg[`CFG_PAR_EN]),
    .par_odd_i(cfg[`CFG_PAR_ODD]),
    .start_mid_o(start_mid),
    .active_o(active),
    .done_o(char_done),
    .data_o(sh_data),
    .frm_err_o(sh_frm),
    .par_err_o(sh_par)
  );

  wire setup = psel & ~penable;
  wire wr = setup & pwrite;
  wire rd = setup & ~pwrite;
  wire hit_cs = (paddr == `OFS_RX_CTL_STATUS);
  wire hit_buf = (paddr == `OFS_RX_DATA_BUF);
  wire hit_cfg = (paddr == `OFS_RX_CONFIG);
  wire err_det = cfg[`CFG_ERR_DET];
  wire adv_wr = wr & hit_cs & pstrb[0] & pwdata[`BIT_READER_ADV];

  // short characters: mask bits above configured length
  wire [3:0] len = 4'd5 + {2'b00, cfg[`CFG_LEN_LSB+1:`CFG_LEN_LSB]};
  wire [7:0] len_mask = 8'hff >> (4'd8 - len);
  // parity flag hidden while parity checking is off
  wire par_vis = par_flag & cfg[`CFG_PAR_EN]; // R14
  wire err_sum = ovr_flag | frm_flag | par_vis; // R7
  wire hit_any = hit_cs | hit_buf | hit_cfg;
  wire ctl_wr = wr & hit_cs & pstrb[0];
  wire buf_touch = setup & hit_buf;

  // control/status word as software sees it
  reg [15:0] ctl_word;
  always @* begin
    ctl_word = 16'h0000;
    ctl_word[`BIT_REV_TX] = rev_tx; // R1
    ctl_word[`BIT_RTS] = rts; // R2
    ctl_word[`BIT_DTR] = dtr; // R3
    ctl_word[`BIT_RX_INT_ENB] = rx_int_enb;
    ctl_word[`BIT_RX_DONE] = rx_done; // R17
    ctl_word[`BIT_REV_RX] = rev_rx; // R18
    ctl_word[`BIT_RX_ACTIVE] = active;
    // advance bit is write-only
    ctl_word[`BIT_READER_ADV] = 1'b0; // R19
  end

  // buffer word: character plus error flags
  reg [15:0] buf_word;
  always @* begin
    buf_word = 16'h0000;
    buf_word[7:0] = rx_char & len_mask; // R15 R16
    if (err_det) begin // R20
      buf_word[`BIT_ERR_SUM] = err_sum; // R7 R8
      buf_word[`BIT_OVR_FLAG] = ovr_flag; // R11
      buf_word[`BIT_FRM_FLAG] = frm_flag; // R12
      buf_word[`BIT_PAR_FLAG] = par_vis; // R13 R14
    end
  end

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    if (hit_cs)
      next_rdata[15:0] = ctl_word;
    else if (hit_buf)
      next_rdata[15:0] = buf_word; // R19
    else if (hit_cfg)
      next_rdata = cfg;
  end

  // set wins: a fresh write re-arms over a start middle
  reg next_reader_adv;
  always @* begin
    next_reader_adv = reader_adv;
    if (init_i)
      next_reader_adv = 1'b0; // R6
    else if (adv_wr)
      next_reader_adv = 1'b1; // R5
    else if (start_mid)
      next_reader_adv = 1'b0; // R6
  end

  // a new character wins over a same-cycle buffer access or advance clear
  reg next_rx_done;
  always @* begin
    next_rx_done = rx_done;
    if (init_i)
      next_rx_done = 1'b0; // R17
    else if (char_done)
      next_rx_done = 1'b1; // R17
    else if (buf_touch | adv_wr)
      next_rx_done = 1'b0; // R17 R5
  end

  // apb answer: one access cycle, no wait states
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce_i) begin
      pready <= setup;
      pslverr <= setup & ~hit_any;
      // refused reads leave the last data in place
      if (rd & hit_any)
        prdata <= next_rdata;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg <= `CFG_RESET;
    end else if (ce_i) begin
      if (wr & hit_cfg)
        cfg <= pwdata;
    end
  end

  // controls that bus initialize clears
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rev_tx <= 1'b0;
      rts <= 1'b0;
      rx_int_enb <= 1'b0;
    end else if (ce_i) begin
      if (init_i) begin
        rev_tx <= 1'b0; // R1
        rts <= 1'b0; // R2
        rx_int_enb <= 1'b0;
      end else if (ctl_wr) begin
        rev_tx <= pwdata[`BIT_REV_TX]; // R1
        rts <= pwdata[`BIT_RTS]; // R2
        rx_int_enb <= pwdata[`BIT_RX_INT_ENB];
      end
    end
  end

  // terminal ready: initialize leaves it alone
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dtr <= 1'b0;
    end else if (ce_i) begin
      if (ctl_wr)
        dtr <= pwdata[`BIT_DTR]; // R3 R4
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reader_adv <= 1'b0;
    end else if (ce_i) begin
      reader_adv <= next_reader_adv; // R5 R6
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_done <= 1'b0;
    end else if (ce_i) begin
      rx_done <= next_rx_done; // R17
    end
  end

  // reverse channel sampled once, read one cycle later
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rev_rx <= 1'b0;
    end else if (ce_i) begin
      rev_rx <= reverse_channel_rx_i; // R18
    end
  end

  // flags replaced on every character, kept through initialize
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_char <= 8'h00;
      ovr_flag <= 1'b0;
      frm_flag <= 1'b0;
      par_flag <= 1'b0;
    end else if (ce_i) begin
      if (char_done) begin
        rx_char <= sh_data; // R15
        ovr_flag <= rx_done; // R11 R9 R10
        frm_flag <= sh_frm; // R12 R9 R10
        par_flag <= sh_par; // R13 R9 R10
      end
    end
  end

  // every pin comes from a flop
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reverse_channel_tx_o <= 1'b0;
      request_to_send_o <= 1'b0;
      force_busy_o <= 1'b0;
      data_terminal_ready_o <= 1'b0;
      reader_advance_o <= 1'b0;
      receiver_done_o <= 1'b0;
    end else if (ce_i) begin
      reverse_channel_tx_o <= rev_tx; // R1
      request_to_send_o <= rts & ~cfg[`CFG_RTS_SEL]; // R2
      force_busy_o <= rts & cfg[`CFG_RTS_SEL]; // R2
      data_terminal_ready_o <= dtr; // R3
      reader_advance_o <= reader_adv; // R5
      receiver_done_o <= rx_done; // R17
    end
  end
endmodule // rx_ctl
`default_nettype wire

//--- hw/rx_ctl_defines.vh
// register offsets, field positions and timing counts for the receive block
`ifndef RX_CTL_DEFINES_VH
`define RX_CTL_DEFINES_VH
`define OFS_RX_CTL_STATUS 12'h000
`define OFS_RX_DATA_BUF 12'h004
`define OFS_RX_CONFIG 12'h008
`define BIT_READER_ADV 0
`define BIT_DTR 1
`define BIT_RTS 2
`define BIT_REV_TX 3
`define BIT_RX_INT_ENB 6
`define BIT_RX_DONE 7
`define BIT_REV_RX 10
`define BIT_RX_ACTIVE 11
`define BIT_PAR_FLAG 12
`define BIT_FRM_FLAG 13
`define BIT_OVR_FLAG 14
`define BIT_ERR_SUM 15
`define CFG_PAR_EN 0
`define CFG_PAR_ODD 1
`define CFG_LEN_LSB 2
`define CFG_RTS_SEL 4
`define CFG_ERR_DET 5
`define CFG_RESET 32'h00000033
`define BAUD_HZ 9600
`define CLK_HZ 10000000
`define BIT_CYCLES (`CLK_HZ / `BAUD_HZ)
`define HALF_CYCLES (`BIT_CYCLES / 2)
// the same two counts sized for the 11-bit bit timer
`define BIT_CNT 11'd1041
`define HALF_CNT 11'd520
`endif

//--- hw/rx_shift.v
// serial character assembler: start, data, optional parity, stop
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_defines.vh"
module rx_shift (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire rxd_i,
  input wire [1:0] len_sel_i,
  input wire par_en_i,
  input wire par_odd_i,
  output reg start_mid_o,
  output reg active_o,
  output reg done_o,
  output reg [7:0] data_o,
  output reg frm_err_o,
  output reg par_err_o
);
  localparam S_IDLE = 2'd0;
  localparam S_START = 2'd1;
  localparam S_BITS = 2'd2;
  localparam S_STOP = 2'd3;
  reg [1:0] state;
  reg [10:0] cnt;
  reg [3:0] idx;
  reg [7:0] shreg;
  reg par_acc;
  wire [3:0] nbits = 4'd5 + {2'b00, len_sel_i} + {3'b000, par_en_i};
  wire tick = (cnt == 11'd0);
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      cnt <= 11'd0;
      idx <= 4'd0;
      shreg <= 8'h00;
      par_acc <= 1'b0;
      start_mid_o <= 1'b0;
      active_o <= 1'b0;
      done_o <= 1'b0;
      data_o <= 8'h00;
      frm_err_o <= 1'b0;
      par_err_o <= 1'b0;
    end else if (ce_i) begin
      start_mid_o <= 1'b0;
      done_o <= 1'b0;
      if (!tick)
        cnt <= cnt - 11'd1;
      case (state)
        S_IDLE: begin
          if (!rxd_i) begin
            state <= S_START;
            cnt <= `HALF_CNT;
          end
        end
        S_START: begin
          if (tick) begin
            if (rxd_i) begin
              state <= S_IDLE;
            end else begin
              start_mid_o <= 1'b1;
              active_o <= 1'b1;
              state <= S_BITS;
              cnt <= `BIT_CNT;
              idx <= 4'd0;
              shreg <= 8'h00;
              par_acc <= par_odd_i;
            end
          end
        end
        S_BITS: begin
          if (tick) begin
            cnt <= `BIT_CNT;
            par_acc <= par_acc ^ rxd_i;
            if (idx < nbits - {3'b000, par_en_i})
              shreg[idx[2:0]] <= rxd_i;
            idx <= idx + 4'd1;
            if (idx == nbits - 4'd1)
              state <= S_STOP;
          end
        end
        S_STOP: begin
          if (tick) begin
            state <= S_IDLE;
            active_o <= 1'b0;
            done_o <= 1'b1;
            data_o <= shreg;
            frm_err_o <= ~rxd_i;
            par_err_o <= par_en_i & par_acc;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // rx_shift
`default_nettype wire
